// ===== inc/mrs_pkg.sv
package mrs_pkg;

	// ----------------------------------------
	// widths and constants
	// ----------------------------------------
	localparam int        DATA_W      = 8;
	localparam int        MSB         = DATA_W - 1;
	localparam int        NIB_W       = 4;
	localparam logic [7:0] DEC_STEP   = 8'h01;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam logic [7:0] ACC_RESET  = 8'h00;
	localparam int        DEC_CYCLES  = 2;

	// ----------------------------------------
	// operation codes from the decoder
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_ROT_RC_ACC  = 3'h0,
		OP_SUB_MEM_ACC = 3'h1,
		OP_SUB_IMM_ACC = 3'h2,
		OP_SUB_MEM_MEM = 3'h3,
		OP_DEC_SKIP    = 3'h4,
		OP_DEC_ACC_SKP = 3'h5
	} mrs_op_type;

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	typedef struct packed {
		logic ov;
		logic z;
		logic ac;
		logic c;
		logic sc;
		logic cz;
	} mrs_flags_type;

	localparam mrs_flags_type FLAGS_RESET = '{default: 1'b0};

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_DUMMY = 2'b10
	} mrs_state_type;

	typedef struct packed {
		mrs_state_type st;
		logic [7:0]    acc;
		mrs_flags_type flags;
		logic          mem_we;
		logic [7:0]    mem_wdata;
		logic          busy;
		logic          done;
		logic          skip;
	} mrs_regs_type;

endpackage

// ===== core/mrs_sub_borrow.sv
`timescale 1ns/100ps
module mrs_sub_borrow
	import mrs_pkg::*;
(
	input  wire logic [7:0]    minuend,
	input  wire logic [7:0]    subtrahend,
	input  wire logic          carry_in,
	input  wire logic          zero_in,
	output logic [7:0]         diff,
	output mrs_flags_type      flags
);
	logic [8:0] full;
	logic [4:0] nib;

	always_comb begin
		full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, ~carry_in};
		nib  = {1'b0, minuend[NIB_W-1:0]} - {1'b0, subtrahend[NIB_W-1:0]}
			- {4'h0, ~carry_in};
		diff = full[MSB:0];
		// RULE6 carry is not-borrow
		flags.c  = ~full[DATA_W];
		// RULE11 nibble borrow, zero, overflow
		flags.ac = ~nib[NIB_W];
		flags.z  = (full[MSB:0] == ZERO_BYTE);
		flags.ov = (minuend[MSB] != subtrahend[MSB]) && (full[MSB] != minuend[MSB]);
		// RULE7 compare and chained zero
		flags.sc = full[MSB] ^ flags.ov;
		flags.cz = flags.z & zero_in;
	end
endmodule

// ===== core/mrs_dec_zero.sv
`timescale 1ns/100ps
module mrs_dec_zero
	import mrs_pkg::*;
(
	input  wire logic [7:0] din,
	output logic [7:0]      dout,
	output logic            is_zero
);
	always_comb begin
		dout    = din - DEC_STEP;
		is_zero = (dout == ZERO_BYTE);
	end
endmodule

// ===== core/mrs_exec.sv
// Function
// RULE1: rotate right through carry into accumulator
// RULE2: rotate writes acc only, carry only
// RULE3: acc minus memory minus not-carry into acc
// RULE4: acc minus immediate minus not-carry into acc
// RULE5: difference to memory, accumulator kept
// RULE6: carry clear on negative, else set
// RULE7: subtracts update all six flags
// RULE8: decrement memory, skip on zero, no flags
// RULE9: decrement into acc, skip on zero
// RULE10: decrement-skip takes two cycles
// RULE11: zero, overflow and nibble borrow defined
`timescale 1ns/100ps
module mrs_exec
	import mrs_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          rst,
	input  wire logic          op_valid,
	input  mrs_op_type         op_code,
	input  wire logic [7:0]    mem_rdata,
	input  wire logic [7:0]    imm_data,
	input  wire logic          acc_wr_en,
	input  wire logic [7:0]    acc_wr_data,
	input  wire logic          flags_wr_en,
	input  mrs_flags_type      flags_wr_data,
	output logic [7:0]         acc_out,
	output mrs_flags_type      flags_out,
	output logic               mem_we,
	output logic [7:0]         mem_wdata,
	output logic               busy,
	output logic               done,
	output logic               skip
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	mrs_regs_type  s_ff;
	mrs_regs_type  nxt_s;

	logic          accept;
	logic [7:0]    sub_b;
	logic [7:0]    sub_diff;
	mrs_flags_type sub_flags;
	logic [7:0]    dec_val;
	logic          dec_zero;

	assign accept = op_valid && (s_ff.st == ST_IDLE);

	// ----------------------------------------
	// arithmetic
	// ----------------------------------------
	assign sub_b = (op_code == OP_SUB_IMM_ACC) ? imm_data : mem_rdata;

	mrs_sub_borrow u_sub (
		.minuend    (s_ff.acc),
		.subtrahend (sub_b),
		.carry_in   (s_ff.flags.c),
		.zero_in    (s_ff.flags.z),
		.diff       (sub_diff),
		.flags      (sub_flags)
	);

	mrs_dec_zero u_dec (
		.din     (mem_rdata),
		.dout    (dec_val),
		.is_zero (dec_zero)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_s        = s_ff;
		nxt_s.mem_we = 1'b0;
		nxt_s.done   = 1'b0;
		case (s_ff.st)
			ST_IDLE: begin
				nxt_s.skip = 1'b0;
				if (accept) begin
					case (op_code)
						// RULE1 rotate right through carry
						// RULE2 carry only, no memory write
						OP_ROT_RC_ACC: begin
							nxt_s.acc     = {s_ff.flags.c, mem_rdata[MSB:1]};
							nxt_s.flags.c = mem_rdata[0];
							nxt_s.done    = 1'b1;
						end
						// RULE3 memory operand into acc
						// RULE4 immediate operand into acc
						// RULE6 carry from borrow
						// RULE7 all six flags
						OP_SUB_MEM_ACC, OP_SUB_IMM_ACC: begin
							nxt_s.acc   = sub_diff;
							nxt_s.flags = sub_flags;
							nxt_s.done  = 1'b1;
						end
						// RULE5 result to memory, acc kept
						OP_SUB_MEM_MEM: begin
							nxt_s.mem_we    = 1'b1;
							nxt_s.mem_wdata = sub_diff;
							nxt_s.flags     = sub_flags;
							nxt_s.done      = 1'b1;
						end
						// RULE8 decrement memory, flags kept
						OP_DEC_SKIP: begin
							nxt_s.mem_we    = 1'b1;
							nxt_s.mem_wdata = dec_val;
							nxt_s.skip      = dec_zero;
							nxt_s.busy      = 1'b1;
							nxt_s.st        = ST_DUMMY;
						end
						// RULE9 decrement into acc, memory kept
						OP_DEC_ACC_SKP: begin
							nxt_s.acc  = dec_val;
							nxt_s.skip = dec_zero;
							nxt_s.busy = 1'b1;
							nxt_s.st   = ST_DUMMY;
						end
						default: begin
							nxt_s.done = 1'b0;
						end
					endcase
				end else begin
					if (acc_wr_en) begin
						nxt_s.acc = acc_wr_data;
					end
					if (flags_wr_en) begin
						nxt_s.flags = flags_wr_data;
					end
				end
			end
			// RULE10 dummy cycle while next is fetched
			ST_DUMMY: begin
				nxt_s.busy = 1'b0;
				nxt_s.done = 1'b1;
				nxt_s.st   = ST_IDLE;
			end
			default: begin
				nxt_s.st   = ST_IDLE;
				nxt_s.busy = 1'b0;
				nxt_s.skip = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_ff.st        <= ST_IDLE;
			s_ff.acc       <= ACC_RESET;
			s_ff.flags     <= FLAGS_RESET;
			s_ff.mem_we    <= 1'b0;
			s_ff.mem_wdata <= ZERO_BYTE;
			s_ff.busy      <= 1'b0;
			s_ff.done      <= 1'b0;
			s_ff.skip      <= 1'b0;
		end else begin
			s_ff           <= nxt_s;
		end
	end

	assign acc_out   = s_ff.acc;
	assign flags_out = s_ff.flags;
	assign mem_we    = s_ff.mem_we;
	assign mem_wdata = s_ff.mem_wdata;
	assign busy      = s_ff.busy;
	assign done      = s_ff.done;
	assign skip      = s_ff.skip;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// RULE1 rotate result bits
	a_rot_acc_bits: assert property (@(posedge core_clk) disable iff (rst) // RULE1
		accept && op_code == OP_ROT_RC_ACC |=>
			acc_out == {$past(flags_out.c), $past(mem_rdata[7:1])}
			&& flags_out.c == $past(mem_rdata[0]))
		else $error("rotate result wrong");

	// RULE2 rotate side effects
	a_rot_no_side: assert property (@(posedge core_clk) disable iff (rst) // RULE2
		accept && op_code == OP_ROT_RC_ACC |=>
			!mem_we && flags_out.z == $past(flags_out.z)
			&& flags_out.ov == $past(flags_out.ov)
			&& flags_out.ac == $past(flags_out.ac)
			&& flags_out.sc == $past(flags_out.sc)
			&& flags_out.cz == $past(flags_out.cz))
		else $error("rotate touched memory or flags");

	// RULE3 memory subtract into acc
	a_sub_mem_acc: assert property (@(posedge core_clk) disable iff (rst) // RULE3
		accept && op_code == OP_SUB_MEM_ACC |=>
			acc_out == 8'($past(acc_out) - $past(mem_rdata) - {7'h00, ~$past(flags_out.c)})
			&& !mem_we)
		else $error("subtract memory to acc wrong");

	// RULE4 immediate subtract into acc
	a_sub_imm_acc: assert property (@(posedge core_clk) disable iff (rst) // RULE4
		accept && op_code == OP_SUB_IMM_ACC |=>
			acc_out == 8'($past(acc_out) - $past(imm_data) - {7'h00, ~$past(flags_out.c)}))
		else $error("subtract immediate wrong");

	// RULE5 subtract to memory
	a_sub_to_mem: assert property (@(posedge core_clk) disable iff (rst) // RULE5
		accept && op_code == OP_SUB_MEM_MEM |=>
			mem_we && $stable(acc_out)
			&& mem_wdata == 8'($past(acc_out) - $past(mem_rdata) - {7'h00, ~$past(flags_out.c)})
			##1 (!mem_we || $past(accept)))
		else $error("subtract to memory wrong");

	// RULE6 carry is not-borrow
	a_sub_carry: assert property (@(posedge core_clk) disable iff (rst) // RULE6
		accept && (op_code == OP_SUB_MEM_ACC || op_code == OP_SUB_IMM_ACC
			|| op_code == OP_SUB_MEM_MEM) |=>
			flags_out.c == ({1'b0, $past(acc_out)} >=
				({1'b0, $past(sub_b)} + {8'h00, ~$past(flags_out.c)})))
		else $error("subtract carry wrong");

	// RULE7 chained zero and compare flags
	a_sub_flag_set: assert property (@(posedge core_clk) disable iff (rst) // RULE7
		accept && op_code == OP_SUB_MEM_ACC |=>
			flags_out.cz == (flags_out.z && $past(flags_out.z))
			&& flags_out.sc == (acc_out[7] ^ flags_out.ov))
		else $error("compare or chained zero flag wrong");

	// RULE11 zero and overflow meaning
	a_sub_zero_ov: assert property (@(posedge core_clk) disable iff (rst) // RULE11
		accept && op_code == OP_SUB_MEM_ACC |=>
			flags_out.z == (acc_out == 8'h00)
			&& flags_out.ov == (($past(acc_out[7]) != $past(mem_rdata[7]))
				&& (acc_out[7] != $past(acc_out[7]))))
		else $error("zero or overflow flag wrong");

	// RULE8 decrement memory without flags
	a_dec_mem: assert property (@(posedge core_clk) disable iff (rst) // RULE8
		accept && op_code == OP_DEC_SKIP |=>
			mem_we && mem_wdata == 8'($past(mem_rdata) - 8'h01)
			&& $stable(flags_out) && $stable(acc_out))
		else $error("decrement memory wrong");

	// RULE9 decrement into acc
	a_dec_acc: assert property (@(posedge core_clk) disable iff (rst) // RULE9
		accept && op_code == OP_DEC_ACC_SKP |=>
			!mem_we && acc_out == 8'($past(mem_rdata) - 8'h01) && $stable(flags_out))
		else $error("decrement to acc wrong");

	// RULE10 two cycles with skip decision
	a_dec_two_cyc: assert property (@(posedge core_clk) disable iff (rst) // RULE10
		accept && (op_code == OP_DEC_SKIP || op_code == OP_DEC_ACC_SKP) |=>
			busy && !done ##1 done && !busy
			&& skip == ($past(mem_rdata, 2) == 8'h01))
		else $error("decrement skip timing wrong");

	// rotate and immediate subtract finish next edge
	a_one_cyc_done: assert property (@(posedge core_clk) disable iff (rst) // RULE1
		accept && (op_code == OP_ROT_RC_ACC || op_code == OP_SUB_IMM_ACC) |=>
			done && !busy && !skip)
		else $error("single cycle op timing wrong");

	// RULE10 dummy cycle ignores requests
	a_busy_refuse: assert property (@(posedge core_clk) disable iff (rst) // RULE10
		busy |=>
			!busy && done && !mem_we && $stable(acc_out) && $stable(flags_out))
		else $error("request taken during dummy cycle");

	// RULE2 only memory-writing ops strobe
	a_mem_we_src: assert property (@(posedge core_clk) disable iff (rst) // RULE2
		mem_we |->
			$past(accept) && ($past(op_code) == OP_SUB_MEM_MEM
			|| $past(op_code) == OP_DEC_SKIP))
		else $error("memory write without a writing op");

	// RULE8 skip only with a decrement
	a_skip_window: assert property (@(posedge core_clk) disable iff (rst) // RULE8
		!busy && !done |-> !skip)
		else $error("skip raised outside a decrement");

	// RULE11 nibble borrow flag
	a_sub_nib_flag: assert property (@(posedge core_clk) disable iff (rst) // RULE11
		accept && op_code == OP_SUB_IMM_ACC |=>
			flags_out.ac == ({1'b0, $past(acc_out[3:0])} >=
				({1'b0, $past(imm_data[3:0])} + {4'h0, ~$past(flags_out.c)})))
		else $error("nibble borrow flag wrong");

	// RULE7 flags of subtract to memory
	a_sub_mem_flags: assert property (@(posedge core_clk) disable iff (rst) // RULE7
		accept && op_code == OP_SUB_MEM_MEM |=>
			flags_out.z == (mem_wdata == 8'h00)
			&& flags_out.cz == (flags_out.z && $past(flags_out.z)))
		else $error("subtract to memory flags wrong");

	// RULE4 immediate subtract leaves memory alone
	a_sub_imm_side: assert property (@(posedge core_clk) disable iff (rst) // RULE4
		accept && op_code == OP_SUB_IMM_ACC |=>
			!mem_we && flags_out.z == (acc_out == 8'h00))
		else $error("immediate subtract side effect wrong");

endmodule

// ===== tb/mrs_exec_tb.sv
`timescale 1ns/100ps
module mrs_exec_tb
	import mrs_pkg::*;
;
	logic          core_clk;
	logic          rst;
	logic          op_valid;
	mrs_op_type    op_code;
	logic [7:0]    mem_rdata;
	logic [7:0]    imm_data;
	logic          acc_wr_en;
	logic [7:0]    acc_wr_data;
	logic          flags_wr_en;
	mrs_flags_type flags_wr_data;
	logic [7:0]    acc_out;
	mrs_flags_type flags_out;
	logic          mem_we;
	logic [7:0]    mem_wdata;
	logic          busy;
	logic          done;
	logic          skip;
	int            n_mismatch = 0;
	int            n_compared = 0;
	logic [7:0]    ta [6] = '{8'h50, 8'h80, 8'h10, 8'h05, 8'h05, 8'h7f};
	logic [7:0]    tm [6] = '{8'h70, 8'h01, 8'h10, 8'h04, 8'h04, 8'hff};
	logic [5:0]    tcz    = 6'h0a;
	logic [5:0]    tpz    = 6'h0e;
	mrs_op_type    sops [3] = '{OP_SUB_MEM_ACC, OP_SUB_IMM_ACC, OP_SUB_MEM_MEM};

	mrs_exec dut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
		.mem_rdata(mem_rdata), .imm_data(imm_data), .acc_wr_en(acc_wr_en),
		.acc_wr_data(acc_wr_data), .flags_wr_en(flags_wr_en), .flags_wr_data(flags_wr_data),
		.acc_out(acc_out), .flags_out(flags_out), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.busy(busy), .done(done), .skip(skip));

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask

	task automatic preload(input logic [7:0] a, input mrs_flags_type f);
		acc_wr_en = 1'b1;
		acc_wr_data = a;
		flags_wr_en = 1'b1;
		flags_wr_data = f;
		tick;
		acc_wr_en = 1'b0;
		flags_wr_en = 1'b0;
	endtask

	task automatic start(input mrs_op_type op, input logic [7:0] m, input logic [7:0] imm);
		op_valid = 1'b1;
		op_code = op;
		mem_rdata = m;
		imm_data = imm;
		tick;
		op_valid = 1'b0;
		mem_rdata = ~m;
	endtask

	task automatic rot(input logic [7:0] a, input logic [7:0] m, input logic c);
		mrs_flags_type f;
		f = 6'h2a;
		f.c = c;
		preload(a, f);
		start(OP_ROT_RC_ACC, m, 8'h00);
		f.c = m[0];
		chk("rot acc", {c, m[7:1]}, acc_out);
		chk("rot flags", {2'h0, f}, {2'h0, flags_out});
		chk("rot we", 8'h00, {7'h0, mem_we});
		chk("rot done", 8'h01, {7'h0, done});
	endtask

	task automatic sub(input mrs_op_type op, input logic [7:0] a, input logic [7:0] m,
		input logic c, input logic pz);
		mrs_flags_type f;
		logic [8:0]    d;
		logic [4:0]    n;
		logic          tomem;
		f = 6'h00;
		f.c = c;
		f.z = pz;
		preload(a, f);
		tomem = (op == OP_SUB_MEM_MEM);
		d = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
		n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
		f.c = ~d[8];
		f.ac = ~n[4];
		f.z = (d[7:0] == 8'h00);
		f.ov = (a[7] != m[7]) && (d[7] != a[7]);
		f.sc = d[7] ^ f.ov;
		f.cz = f.z & pz;
		if (op == OP_SUB_IMM_ACC) begin
			start(op, ~m, m);
		end else begin
			start(op, m, ~m);
		end
		chk("sub acc", tomem ? a : d[7:0], acc_out);
		chk("sub flags", {2'h0, f}, {2'h0, flags_out});
		chk("sub we", {7'h0, tomem}, {7'h0, mem_we});
		if (tomem) chk("sub wdata", d[7:0], mem_wdata);
		chk("sub done", 8'h01, {7'h0, done});
	endtask

	task automatic dec(input mrs_op_type op, input logic [7:0] a, input logic [7:0] m);
		logic [7:0] r;
		logic       tomem;
		r = m - 8'h01;
		tomem = (op == OP_DEC_SKIP);
		preload(a, 6'h15);
		op_valid = 1'b1;
		op_code = op;
		mem_rdata = m;
		tick;
		// rotate held during the dummy cycle must be ignored
		op_code = OP_ROT_RC_ACC;
		mem_rdata = ~m;
		chk("dec busy", 8'h01, {7'h0, busy});
		chk("dec done1", 8'h00, {7'h0, done});
		chk("dec we", {7'h0, tomem}, {7'h0, mem_we});
		if (tomem) chk("dec wdata", r, mem_wdata);
		chk("dec acc", tomem ? a : r, acc_out);
		tick;
		op_valid = 1'b0;
		chk("dec done2", 8'h01, {7'h0, done});
		chk("dec busy2", 8'h00, {6'h0, busy, mem_we});
		chk("dec skip", {7'h0, r == 8'h00}, {7'h0, skip});
		chk("dec flags", 8'h15, {2'h0, flags_out});
		tick;
		chk("dec end", 8'h00, {6'h0, skip, done});
		chk("dec acc2", tomem ? a : r, acc_out);
	endtask

	task automatic complete_run;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial begin
		#20000;
		n_mismatch++;
		complete_run;
	end

	initial begin
		rst = 1'b1;
		op_valid = 1'b0;
		op_code = OP_ROT_RC_ACC;
		mem_rdata = 8'h00;
		imm_data = 8'h00;
		acc_wr_en = 1'b0;
		acc_wr_data = 8'h00;
		flags_wr_en = 1'b0;
		flags_wr_data = 6'h00;
		repeat (5) @(posedge core_clk);
		#1;
		rst = 1'b0;
		chk("rst acc", 8'h00, acc_out);
		chk("rst flags", 8'h00, {2'h0, flags_out});
		chk("rst ctl", 8'h00, {4'h0, mem_we, busy, done, skip});
		rot(8'h00, 8'ha5, 1'b0);
		rot(8'hff, 8'h5a, 1'b1);
		for (int o = 0; o < 3; o++) begin
			for (int i = 0; i < 6; i++) begin
				sub(sops[o], ta[i], tm[i], tcz[i], tpz[i]);
			end
		end
		dec(OP_DEC_SKIP, 8'h3c, 8'h01);
		dec(OP_DEC_SKIP, 8'h3c, 8'h00);
		dec(OP_DEC_SKIP, 8'h3c, 8'h80);
		dec(OP_DEC_ACC_SKP, 8'h3c, 8'h01);
		dec(OP_DEC_ACC_SKP, 8'h3c, 8'h00);
		dec(OP_DEC_ACC_SKP, 8'h3c, 8'h80);
		// back-to-back ops win over a held accumulator load
		preload(8'h81, 6'h00);
		tick;
		acc_wr_en = 1'b1;
		acc_wr_data = 8'h3c;
		op_valid = 1'b1;
		op_code = OP_ROT_RC_ACC;
		mem_rdata = 8'h03;
		tick;
		chk("b2b rot", 8'h01, acc_out);
		op_code = OP_SUB_MEM_ACC;
		mem_rdata = 8'h01;
		tick;
		op_valid = 1'b0;
		chk("b2b sub", 8'h00, acc_out);
		chk("b2b flags", 8'h1c, {2'h0, flags_out});
		chk("b2b done", 8'h01, {7'h0, done});
		tick;
		acc_wr_en = 1'b0;
		chk("idle load", 8'h3c, acc_out);
		complete_run;
	end
endmodule
